/* File: inc/pmt_pkg.sv */
/*
  Package for the 8-bit period match timer: register offsets, field positions,
  reset values, timing constants and the carrier types shared by the design.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package pmt_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PMT_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PMT_OFS_COUNT   = 8'h04;
  localparam logic [7:0] PMT_OFS_PERIOD  = 8'h08;
  localparam logic [7:0] PMT_OFS_FLAGS   = 8'h0C;
  localparam logic [7:0] PMT_OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] PMT_OFS_INTCTL  = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PMT_CTL_PRE_LSB  = 0;
  localparam int PMT_CTL_RUN_BIT  = 2;
  localparam int PMT_CTL_POST_LSB = 3;
  localparam int PMT_FLAG_BIT     = 1;
  localparam int PMT_IE_BIT       = 1;
  localparam int PMT_PERIPHERAL_IRQ_MASTER_ENABLE_BIT     = 0;
  localparam int PMT_GIE_BIT      = 1;

  // Writable masks of the 8-bit registers; unimplemented bits read zero.
  localparam logic [7:0] PMT_CTL_MASK  = 8'h7F;
  localparam logic [7:0] PMT_FLAG_MASK = 8'h02;
  localparam logic [7:0] PMT_IE_MASK   = 8'h02;
  localparam logic [7:0] PMT_ICTL_MASK = 8'h03;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PMT_RST_CONTROL = 8'h00;
  localparam logic [7:0] PMT_RST_COUNT   = 8'h00;
  localparam logic [7:0] PMT_RST_PERIOD  = 8'hFF;
  localparam logic [7:0] PMT_RST_ZERO8   = 8'h00;

  // ----------------------------------------------------------------------
  // Timing: instruction clock is the system clock divided by four
  // ----------------------------------------------------------------------
  localparam int         PMT_INSN_DIV     = 4;
  localparam logic [1:0] PMT_INSN_LAST    = 2'(PMT_INSN_DIV - 1);
  localparam logic [3:0] PMT_PRE_LAST_1   = 4'h0;
  localparam logic [3:0] PMT_PRE_LAST_4   = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST_16  = 4'hF;
  localparam logic [1:0] PMT_PRE_CODE_1   = 2'b00;
  localparam logic [1:0] PMT_PRE_CODE_4   = 2'b01;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       run_enable;
    logic [1:0] prescale_select;
    logic [3:0] postscale_select;
  } pmt_ctl_t;

  typedef struct packed {
    logic       wr_count;
    logic       wr_control;
    logic [7:0] wdata;
  } pmt_wr_t;

endpackage

/* File: src/pmt_prescaler.sv */
/*
  Instruction-clock divider and selectable prescaler of the period match timer.
  Assumes a clock enable from the top and a synchronous clear pulse from count and control writes.
*/
`timescale 1ns/1ps
module pmt_prescaler (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // Control
  input  wire logic             run_i,
  input  wire logic             clear_i,
  input  wire logic [1:0]       prescale_select_i,
  // Output
  output logic                  tick_o
);
  import pmt_pkg::*;

  logic [1:0] insn_div_r;
  logic [3:0] pre_cnt_r;
  logic [3:0] pre_last;
  logic       insn_tick;

  // Last count of the selected prescale ratio.
  always_comb begin
    unique case (prescale_select_i)
      PMT_PRE_CODE_1: pre_last = PMT_PRE_LAST_1;
      PMT_PRE_CODE_4: pre_last = PMT_PRE_LAST_4;
      default:        pre_last = PMT_PRE_LAST_16;
    endcase
  end

  // The instruction clock free-runs so the timer sees the same Q-cycle cadence as the CPU.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      insn_div_r <= '0;
    end else if (clk_en_i) begin
      insn_div_r <= insn_div_r + 2'd1;
    end
  end

  assign insn_tick = (insn_div_r == PMT_INSN_LAST);

  // Prescale counter; cleared by count and control writes, held while the timer is off.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (clear_i) begin
        pre_cnt_r <= '0;
      end else if (run_i && insn_tick) begin
        pre_cnt_r <= (pre_cnt_r >= pre_last) ? 4'h0 : pre_cnt_r + 4'd1;
      end
    end
  end

  assign tick_o = run_i && !clear_i && insn_tick && (pre_cnt_r >= pre_last);

endmodule

/* File: src/pmt_postscaler.sv */
/*
  Postscaler of the period match timer: counts match events and pulses at the ratio.
  Assumes match pulses and a synchronous clear from the top.
*/
`timescale 1ns/1ps
module pmt_postscaler (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             match_i,
  input  wire logic [3:0]       postscale_select_i,
  // Output
  output logic                  out_o
);
  import pmt_pkg::*;

  logic [3:0] post_cnt_r;

  // Count matches; the field value is the last count, so ratio is field plus one.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (clear_i) begin
        post_cnt_r <= '0;
      end else if (match_i) begin
        post_cnt_r <= (post_cnt_r >= postscale_select_i) ? 4'h0 : post_cnt_r + 4'd1;
      end
    end
  end

  assign out_o = match_i && !clear_i && (post_cnt_r >= postscale_select_i);

endmodule

/* File: src/pmt_timer.sv */
/*
  Top of the 8-bit period match timer with its APB register slave.
  Assumes a 100 MHz system clock, an APB master on the same clock and
  a CPU-side reset that covers every kind of device reset.
  Writes land at the edge that completes the access; reads are captured one edge earlier.
*/
`timescale 1ns/1ps
module pmt_timer (
  // Clock, reset and enable
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  input  wire logic [3:0]       pstrb_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Interrupt request
  output logic                  irq_o
);
  import pmt_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  pmt_ctl_t   ctl_r;
  logic [7:0] count_value_r;
  logic [7:0] period_value_r;
  logic       flag_r;
  logic       irq_en_r;
  logic       peripheral_irq_master_enable_r;
  logic       gie_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;

  logic       pre_tick;
  logic       match;
  logic       post_out;
  logic       wr_access;
  logic       scaler_clear;
  logic       known_addr;
  logic [7:0] ctl_byte;
  pmt_wr_t    wr;

  // A write takes effect in the access cycle while pready is high.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle. The write is taken while
  // pready stands, so a register changes exactly at the edge the master sees complete.
  assign wr_access  = psel_i && penable_i && pwrite_i && pready_r && pstrb_i[0];
  assign known_addr = hit(paddr_i, PMT_OFS_CONTROL) || hit(paddr_i, PMT_OFS_COUNT) ||
                      hit(paddr_i, PMT_OFS_PERIOD)  || hit(paddr_i, PMT_OFS_FLAGS) ||
                      hit(paddr_i, PMT_OFS_IRQ_EN)  || hit(paddr_i, PMT_OFS_INTCTL);
  assign wr.wr_count   = wr_access && hit(paddr_i, PMT_OFS_COUNT);
  assign wr.wr_control = wr_access && hit(paddr_i, PMT_OFS_CONTROL);
  assign wr.wdata      = pwdata_i[7:0];
  assign scaler_clear  = wr.wr_count || wr.wr_control;
  assign ctl_byte      = {1'b0, ctl_r.postscale_select, ctl_r.run_enable,
                          ctl_r.prescale_select};

  // ----------------------------------------------------------------------
  // Prescaler and postscaler
  // ----------------------------------------------------------------------
  pmt_prescaler u_pre (
    .ref_clk_i         (ref_clk_i),
    .rst_n_i           (rst_n_i),
    .clk_en_i          (clk_en_i),
    .run_i             (ctl_r.run_enable),
    .clear_i           (scaler_clear),
    .prescale_select_i (ctl_r.prescale_select),
    .tick_o            (pre_tick)
  );

  // A match is counted on the increment that wraps the count to zero.
  assign match = pre_tick && (count_value_r == period_value_r);

  pmt_postscaler u_post (
    .ref_clk_i          (ref_clk_i),
    .rst_n_i            (rst_n_i),
    .clk_en_i           (clk_en_i),
    .clear_i            (scaler_clear),
    .match_i            (match),
    .postscale_select_i (ctl_r.postscale_select),
    .out_o              (post_out)
  );

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Writing control touches neither the count nor the period.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_r <= pmt_ctl_t'(PMT_RST_CONTROL[6:0]);
    end else if (clk_en_i && wr.wr_control) begin
      ctl_r.prescale_select  <= wr.wdata[PMT_CTL_PRE_LSB +: 2];
      ctl_r.run_enable       <= wr.wdata[PMT_CTL_RUN_BIT];
      ctl_r.postscale_select <= wr.wdata[PMT_CTL_POST_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------------
  // Software writes win over a coincident increment; the new value is not bumped.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_value_r <= PMT_RST_COUNT;
    end else if (clk_en_i) begin
      if (wr.wr_count) begin
        count_value_r <= wr.wdata;
      end else if (match) begin
        count_value_r <= PMT_RST_COUNT;
      end else if (pre_tick) begin
        count_value_r <= count_value_r + 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Period register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_value_r <= PMT_RST_PERIOD;
    end else if (clk_en_i && wr_access && hit(paddr_i, PMT_OFS_PERIOD)) begin
      period_value_r <= wr.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flag and enables
  // ----------------------------------------------------------------------
  // The postscaler event wins over a same-cycle software clear so no event is lost.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (post_out) begin
        flag_r <= 1'b1;
      end else if (wr_access && hit(paddr_i, PMT_OFS_FLAGS)) begin
        flag_r <= wr.wdata[PMT_FLAG_BIT];
      end
    end
  end

  // Enable bits for the request gate.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_r <= 1'b0;
      peripheral_irq_master_enable_r   <= 1'b0;
      gie_r    <= 1'b0;
    end else if (clk_en_i && wr_access) begin
      if (hit(paddr_i, PMT_OFS_IRQ_EN)) begin
        irq_en_r <= wr.wdata[PMT_IE_BIT];
      end
      if (hit(paddr_i, PMT_OFS_INTCTL)) begin
        peripheral_irq_master_enable_r <= wr.wdata[PMT_PERIPHERAL_IRQ_MASTER_ENABLE_BIT];
        gie_r  <= wr.wdata[PMT_GIE_BIT];
      end
    end
  end

  // Registered request; it lags the flag by one clock.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
    end else if (clk_en_i) begin
      irq_r <= flag_r && irq_en_r && peripheral_irq_master_enable_r && gie_r;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  // Read data is captured with pready so it stands for the completing edge.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (clk_en_i) begin
      pready_r  <= psel_i && penable_i && !pready_r;
      pslverr_r <= psel_i && penable_i && !pready_r && !known_addr;
      prdata_r  <= '0;
      if (psel_i && penable_i && !pready_r && !pwrite_i) begin
        unique case (1'b1)
          hit(paddr_i, PMT_OFS_CONTROL): prdata_r[7:0] <= ctl_byte & PMT_CTL_MASK;
          hit(paddr_i, PMT_OFS_COUNT):   prdata_r[7:0] <= count_value_r;
          hit(paddr_i, PMT_OFS_PERIOD):  prdata_r[7:0] <= period_value_r;
          hit(paddr_i, PMT_OFS_FLAGS):   prdata_r[7:0] <= {6'd0, flag_r, 1'b0} & PMT_FLAG_MASK;
          hit(paddr_i, PMT_OFS_IRQ_EN):  prdata_r[7:0] <= {6'd0, irq_en_r, 1'b0} & PMT_IE_MASK;
          hit(paddr_i, PMT_OFS_INTCTL):  prdata_r[7:0] <= {6'd0, gie_r, peripheral_irq_master_enable_r} & PMT_ICTL_MASK;
          default:                       prdata_r[7:0] <= PMT_RST_ZERO8;
        endcase
      end
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o     = irq_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_match_wraps_zero: assert property (
    clk_en_i && match && !wr.wr_count |=> count_value_r == PMT_RST_COUNT)
    else $error("count did not wrap to zero after match");

  a_count_increments: assert property (
    clk_en_i && pre_tick && !match && !wr.wr_count |=> count_value_r == $past(count_value_r) + 8'd1)
    else $error("count did not increment on prescaled tick");

  a_stop_holds_count: assert property (
    clk_en_i && !ctl_r.run_enable && !wr.wr_count |=> $stable(count_value_r))
    else $error("count moved while timer stopped");

  a_ctl_write_keeps: assert property (
    clk_en_i && wr.wr_control |=> $stable(count_value_r))
    else $error("control write changed the count");

  a_scaler_clear_tick: assert property (
    clk_en_i && scaler_clear |=> u_pre.pre_cnt_r == 4'h0 && u_post.post_cnt_r == 4'h0)
    else $error("prescaler or postscaler not cleared by write");

  a_post_sets_flag: assert property (
    clk_en_i && post_out |=> flag_r)
    else $error("postscaler output did not set flag");

  a_flag_sticky: assert property (
    flag_r && !(wr_access && hit(paddr_i, PMT_OFS_FLAGS)) |=> flag_r)
    else $error("flag cleared without software write");

  a_irq_gated: assert property (
    irq_o |-> $past(flag_r) && $past(gie_r) && $past(peripheral_irq_master_enable_r) && $past(irq_en_r))
    else $error("interrupt raised without all enables");

  a_period_write: assert property (
    clk_en_i && wr_access && hit(paddr_i, PMT_OFS_PERIOD) |=> period_value_r == $past(pwdata_i[7:0]))
    else $error("period write not stored");

  a_ratio_one: assert property (
    ctl_r.postscale_select == 4'h0 && match && !scaler_clear |-> post_out)
    else $error("ratio 1:1 did not pass every match");

  // Bus answer: one wait state, one-cycle pulses and zero data outside an answer.
  a_pready_pulse: assert property (
    clk_en_i && pready_o |=> !pready_o)
    else $error("pready stood longer than one cycle");

  a_pready_answer: assert property (
    clk_en_i && psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait state");

  a_err_with_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error response without pready");

  a_rdata_idle: assert property (
    !pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside an answer");

  a_count_read: assert property (
    clk_en_i && psel_i && penable_i && !pready_o && !pwrite_i && hit(paddr_i, PMT_OFS_COUNT)
    |=> prdata_o[7:0] == $past(count_value_r))
    else $error("count read returned a wrong value");

  a_period_read: assert property (
    clk_en_i && psel_i && penable_i && !pready_o && !pwrite_i && hit(paddr_i, PMT_OFS_PERIOD)
    |=> prdata_o[7:0] == $past(period_value_r))
    else $error("period read returned a wrong value");

  a_count_write: assert property (
    clk_en_i && wr.wr_count |=> count_value_r == $past(pwdata_i[7:0]))
    else $error("count write not stored");

  a_ctl_keeps_period: assert property (
    clk_en_i && wr.wr_control |=> $stable(period_value_r))
    else $error("control write changed the period");

  // Datapath: ticks ride the instruction clock and need the run bit.
  a_tick_spacing: assert property (
    clk_en_i && pre_tick |=> !pre_tick [*3])
    else $error("prescaled ticks closer than one instruction cycle");

  a_tick_needs_run: assert property (
    pre_tick |-> ctl_r.run_enable)
    else $error("tick while the timer is stopped");

  a_post_on_match: assert property (
    post_out |-> match)
    else $error("postscaler output without a match");

  // Request gate: the request follows the flag and all enables by one clock.
  a_flag_clear: assert property (
    clk_en_i && wr_access && hit(paddr_i, PMT_OFS_FLAGS) && !post_out && !wr.wdata[PMT_FLAG_BIT]
    |=> !flag_r)
    else $error("flag not cleared by software write");

  a_irq_follows: assert property (
    clk_en_i && flag_r && irq_en_r && peripheral_irq_master_enable_r && gie_r |=> irq_o)
    else $error("request missing with flag and all enables set");

  a_irq_blocked: assert property (
    clk_en_i && !(flag_r && irq_en_r && peripheral_irq_master_enable_r && gie_r) |=> !irq_o)
    else $error("request raised without flag and all enables");

  // Main scenarios that the bench is expected to reach.
  c_match_seen:  cover property (match);
  c_flag_set:    cover property (post_out ##1 flag_r);
  c_irq_raised:  cover property (irq_o);
  c_ctl_write:   cover property (wr.wr_control && ctl_r.run_enable);
  c_freeze:      cover property (!clk_en_i && ctl_r.run_enable);

endmodule

/* File: verif/pmt_timer_tb.sv */
/*
  Self-checking bench for the period match timer: APB read and write tasks
  and directed sequences of register accesses with expected values.
  Assumes the timer package and the timer top are compiled ahead of this file.
*/
`timescale 1ns/1ps
module pmt_timer_tb;
  import pmt_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  int          failures;
  int          compares;
  time         t1;
  logic [7:0]  ofs [6] = '{PMT_OFS_CONTROL, PMT_OFS_COUNT, PMT_OFS_PERIOD,
                           PMT_OFS_FLAGS, PMT_OFS_IRQ_EN, PMT_OFS_INTCTL};
  logic [7:0]  rstv [6] = '{PMT_RST_CONTROL, PMT_RST_COUNT, PMT_RST_PERIOD,
                            8'h00, 8'h00, 8'h00};
  int          tpre [6] = '{0, 1, 2, 3, 0, 0};
  int          tpost [6] = '{0, 0, 0, 0, 15, 5};
  int          tper [6] = '{3, 3, 3, 3, 3, 9};

  // The clock enable is dropped once, in mid-count, to show that all state holds.
  pmt_timer i_dut (
    .ref_clk_i (clk),
    .rst_n_i   (rst_n),
    .clk_en_i  (clk_en),
    .psel_i    (psel),
    .penable_i (penable),
    .pwrite_i  (pwrite),
    .paddr_i   (paddr),
    .pwdata_i  (pwdata),
    .pstrb_i   (pstrb),
    .prdata_o  (prdata),
    .pready_o  (pready),
    .pslverr_o (pslverr),
    .irq_o     (irq)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle edge
  // behind so that a following call never assigns psel twice in a step.
  task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd,
                     input logic [3:0] strb);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= addr;
    pwdata  <= wd;
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    apb(1'b1, addr, {24'h0000_00, d}, 4'hF);
  endtask

  task automatic rd(input logic [7:0] addr);
    apb(1'b0, addr, 32'h0000_0000, 4'hF);
  endtask

  // Bounded wait for the interrupt request to reach a level.
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      failures++;
      report_and_stop();
    end
  endtask

  function automatic int pre_div(input int code);
    return (code == 0) ? 1 : ((code == 1) ? 4 : 16);
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n   = 1'b0;
    clk_en  = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, an unmapped word and a write with its low strobe off.
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      check("reset value", rdat, {24'h0000_00, rstv[i]});
    end
    rd(8'h18);
    check("unmapped error", {31'h0, rerr}, 32'h0000_0001);
    check("unmapped data", rdat, 32'h0000_0000);
    apb(1'b1, PMT_OFS_PERIOD, 32'h0000_0012, 4'h0);
    rd(PMT_OFS_PERIOD);
    check("strobe off", rdat, 32'h0000_00FF);
    // Full-width read back while stopped; the count must hold.
    wr(PMT_OFS_PERIOD, 8'hA5);
    wr(PMT_OFS_COUNT, 8'h5A);
    wr(PMT_OFS_CONTROL, 8'h80);
    rd(PMT_OFS_PERIOD);
    check("period", rdat, 32'h0000_00A5);
    rd(PMT_OFS_CONTROL);
    check("control bit 7", rdat, 32'h0000_0000);
    repeat (100) @(posedge clk);
    rd(PMT_OFS_COUNT);
    check("stopped count", rdat, 32'h0000_005A);
    // Divide by 16 ticks every 64 clocks; writes 40 clocks apart keep
    // the count still only if each write clears the prescaler.
    wr(PMT_OFS_CONTROL, 8'h06);
    repeat (40) @(posedge clk);
    wr(PMT_OFS_COUNT, 8'h30);
    repeat (40) @(posedge clk);
    rd(PMT_OFS_COUNT);
    check("count after count write", rdat, 32'h0000_0030);
    wr(PMT_OFS_CONTROL, 8'h06);
    rd(PMT_OFS_COUNT);
    check("count after control write", rdat, 32'h0000_0030);
    repeat (40) @(posedge clk);
    rd(PMT_OFS_COUNT);
    check("prescaler cleared", rdat, 32'h0000_0030);
    repeat (30) @(posedge clk);
    rd(PMT_OFS_COUNT);
    check("one tick", rdat, 32'h0000_0031);
    // Spacing of flag sets for every prescale code and some postscale codes.
    wr(PMT_OFS_IRQ_EN, 8'h02);
    wr(PMT_OFS_INTCTL, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(PMT_OFS_CONTROL, 8'h00);
      wr(PMT_OFS_FLAGS, 8'h00);
      wr(PMT_OFS_PERIOD, 8'(tper[i]));
      wr(PMT_OFS_CONTROL, 8'(tpost[i] * 8 + 4 + tpre[i]));
      wait_irq(1'b1);
      t1 = $time;
      wr(PMT_OFS_FLAGS, 8'h00);
      wait_irq(1'b0);
      wait_irq(1'b1);
      check("match gap", 32'(($time - t1) / 10),
            32'((tper[i] + 1) * 4 * pre_div(tpre[i]) * (tpost[i] + 1)));
    end
    // Freezing the clock enable for 50 clocks stretches a 16-clock gap to 66.
    wr(PMT_OFS_CONTROL, 8'h00);
    wr(PMT_OFS_FLAGS, 8'h00);
    wr(PMT_OFS_PERIOD, 8'h03);
    wr(PMT_OFS_CONTROL, 8'h04);
    wait_irq(1'b1);
    t1 = $time;
    wr(PMT_OFS_FLAGS, 8'h00);
    clk_en <= 1'b0;
    repeat (50) @(posedge clk);
    clk_en <= 1'b1;
    wait_irq(1'b1);
    check("frozen gap", 32'(($time - t1) / 10), 32'h0000_0042);
    // Request only with the flag and all three enables set.
    wr(PMT_OFS_CONTROL, 8'h00);
    wr(PMT_OFS_FLAGS, 8'h02);
    for (int k = 0; k < 8; k++) begin
      wr(PMT_OFS_IRQ_EN, 8'(k % 2) * 8'h02);
      wr(PMT_OFS_INTCTL, 8'(k / 2));
      repeat (2) @(posedge clk);
      check("request", {31'h0, irq}, 32'(k == 7));
    end
    rd(PMT_OFS_FLAGS);
    check("sticky flag", rdat, 32'h0000_0002);
    wr(PMT_OFS_FLAGS, 8'h00);
    repeat (2) @(posedge clk);
    check("request cleared", {31'h0, irq}, 32'h0000_0000);
    // A second reset in mid-run.
    wr(PMT_OFS_PERIOD, 8'h10);
    wr(PMT_OFS_CONTROL, 8'h05);
    repeat (100) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(PMT_OFS_COUNT);
    check("count after reset", rdat, 32'h0000_0000);
    rd(PMT_OFS_PERIOD);
    check("period after reset", rdat, 32'h0000_00FF);
    report_and_stop();
  end
endmodule
